// *** hdl/scl_loader.sv ***
// strap capture, serial configuration loader and host strobe qualification
`timescale 1ns/100ps
module scl_loader
	import scl_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic host_clk_i,
	input wire logic rst_n_i,
	input wire logic eeprom_enable_strap_i,
	input wire logic [1:0] onchip_bus_speed_control_i,
	input wire logic chip_powerdown_n_i,
	input wire logic eeprom_serial_clock_i,
	output logic eeprom_serial_clock_o,
	output logic eeprom_serial_clock_oe_o,
	output logic eeprom_select_o,
	output logic eeprom_select_oe_o,
	output logic eeprom_serial_out_o,
	output logic eeprom_serial_out_oe_o,
	input wire logic eeprom_serial_in_i,
	input wire logic address_qualifier_n_i,
	input wire logic write_strobe_n_i,
	input wire logic read_strobe_n_i,
	output scl_strap_t straps_o,
	output logic config_loaded_o,
	output logic [CFG_BITS-1:0] config_data_o,
	output logic [CNT_W-1:0] host_writes_o,
	output logic [CNT_W-1:0] host_reads_o
);

	// --------------------------------------------------------------
	// pin synchronisers, core domain
	// --------------------------------------------------------------
	logic [3:0] pin_raw;
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic [1:0] spd_s1_q;
	logic [1:0] spd_s2_q;
	assign pin_raw = {eeprom_enable_strap_i, chip_powerdown_n_i, eeprom_serial_clock_i, eeprom_serial_in_i};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin_sync
			always_ff @(posedge core_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					pin_s1_q[gi] <= 1'b0;
					pin_s2_q[gi] <= 1'b0;
				end else begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			spd_s1_q <= 2'h0;
			spd_s2_q <= 2'h0;
		end else begin
			spd_s1_q <= onchip_bus_speed_control_i;
			spd_s2_q <= spd_s1_q;
		end
	end

	logic en_s;
	logic pd_s;
	logic sk_s;
	logic di_s;
	assign en_s = pin_s2_q[3];
	assign pd_s = !pin_s2_q[2];
	assign sk_s = pin_s2_q[1];
	assign di_s = pin_s2_q[0];

	// --------------------------------------------------------------
	// strap capture after reset release
	// --------------------------------------------------------------
	scl_state_t state_q;
	logic [1:0] strap_cnt_q;
	scl_strap_t straps_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_cnt_q <= 2'h0;
			straps_q <= '0;
		end else if (state_q == ST_STRAP) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			straps_q.eeprom_en <= en_s;
			straps_q.big_endian <= sk_s;
			straps_q.bus_16bit <= di_s;
		end
	end
	assign straps_o = straps_q;

	// --------------------------------------------------------------
	// serial clock divider
	// --------------------------------------------------------------
	logic [HALF_W-1:0] half_cnt_q;
	logic [HALF_W-1:0] half_lim;
	logic tick;
	logic active;
	// period per speed code; other codes take the slow period, safe for any part
	assign half_lim = (spd_s2_q == SPEED_125MHZ) ? HALF_FAST : HALF_SLOW;
	assign active = (state_q == ST_CMD || state_q == ST_DATA) && !pd_s;
	assign tick = active && (half_cnt_q >= half_lim);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_cnt_q <= '0;
		end else if (!active || tick) begin
			half_cnt_q <= '0;
		end else begin
			half_cnt_q <= half_cnt_q + 1'b1;
		end
	end

	// --------------------------------------------------------------
	// loader sequence
	// --------------------------------------------------------------
	logic sk_q;
	logic do_q;
	logic cs_q;
	logic [BIT_W-1:0] bit_q;
	logic [CMD_BITS-1:0] cmd_q;
	logic [CFG_BITS-1:0] cfg_q;
	logic loaded_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_STRAP;
			sk_q <= 1'b0;
			do_q <= 1'b0;
			cs_q <= 1'b0;
			bit_q <= '0;
			cmd_q <= '0;
			cfg_q <= '0;
			loaded_q <= 1'b0;
		end else begin
			unique case (state_q)
				ST_STRAP: begin
					if (strap_cnt_q == STRAP_WAIT) begin
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (!straps_q.eeprom_en) begin
						state_q <= ST_DONE;
					end else if (!pd_s) begin
						cs_q <= 1'b1;
						do_q <= READ_CMD[CMD_BITS-1];
						cmd_q <= READ_CMD << 1;
						bit_q <= '0;
						state_q <= ST_CMD;
					end
				end
				ST_CMD: begin
					if (tick) begin
						sk_q <= !sk_q;
						if (sk_q) begin
							// next command bit while clock is low
							do_q <= cmd_q[CMD_BITS-1];
							cmd_q <= cmd_q << 1;
							bit_q <= (bit_q == CMD_LAST) ? '0 : bit_q + 1'b1;
							if (bit_q == CMD_LAST) begin
								do_q <= 1'b0;
								state_q <= ST_DATA;
							end
						end
					end
				end
				ST_DATA: begin
					if (tick) begin
						sk_q <= !sk_q;
						if (sk_q) begin
							cfg_q <= {cfg_q[CFG_BITS-2:0], di_s};
							bit_q <= bit_q + 1'b1;
							if (bit_q == CFG_LAST) begin
								cs_q <= 1'b0;
								loaded_q <= 1'b1;
								state_q <= ST_DONE;
							end
						end
					end
				end
				ST_DONE: begin
					state_q <= ST_DONE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// pin drivers; strap phase leaves the clock pin as input
	// --------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eeprom_serial_clock_oe_o <= 1'b0;
			eeprom_select_oe_o <= 1'b0;
			eeprom_serial_out_oe_o <= 1'b0;
		end else begin
			// tri-state in powerdown
			// clock pin only driven while a frame runs; it doubles as the byte order strap
			eeprom_serial_clock_oe_o <= !pd_s && (state_q == ST_CMD || state_q == ST_DATA);
			eeprom_select_oe_o <= !pd_s && state_q != ST_STRAP;
			eeprom_serial_out_oe_o <= !pd_s && state_q != ST_STRAP;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eeprom_serial_clock_o <= 1'b0;
			eeprom_select_o <= 1'b0;
			eeprom_serial_out_o <= 1'b0;
			config_loaded_o <= 1'b0;
			config_data_o <= '0;
		end else begin
			eeprom_serial_clock_o <= sk_q;
			eeprom_select_o <= cs_q;
			eeprom_serial_out_o <= do_q;
			config_loaded_o <= loaded_q;
			config_data_o <= cfg_q;
		end
	end

	// --------------------------------------------------------------
	// host strobes, host clock domain
	// --------------------------------------------------------------
	logic [2:0] hs1_q;
	logic [2:0] hs2_q;
	logic [2:0] hprev_q;
	logic wr_tgl_q;
	logic rd_tgl_q;
	logic wr_evt;
	logic rd_evt;

	always_ff @(posedge host_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hs1_q <= 3'h7;
			hs2_q <= 3'h7;
			hprev_q <= 3'h7;
		end else begin
			hs1_q <= {address_qualifier_n_i, write_strobe_n_i, read_strobe_n_i};
			hs2_q <= hs1_q;
			hprev_q <= hs2_q;
		end
	end

	assign wr_evt = hprev_q[1] && !hs2_q[1] && !hs2_q[2];
	assign rd_evt = hprev_q[0] && !hs2_q[0] && !hs2_q[2];

	always_ff @(posedge host_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_tgl_q <= 1'b0;
			rd_tgl_q <= 1'b0;
		end else begin
			wr_tgl_q <= wr_tgl_q ^ wr_evt;
			rd_tgl_q <= rd_tgl_q ^ rd_evt;
		end
	end

	// --------------------------------------------------------------
	// access events into the core domain
	// --------------------------------------------------------------
	logic [1:0] ts1_q;
	logic [1:0] ts2_q;
	logic [1:0] ts3_q;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ts1_q <= 2'h0;
			ts2_q <= 2'h0;
			ts3_q <= 2'h0;
			host_writes_o <= '0;
			host_reads_o <= '0;
		end else begin
			ts1_q <= {wr_tgl_q, rd_tgl_q};
			ts2_q <= ts1_q;
			ts3_q <= ts2_q;
			host_writes_o <= host_writes_o + CNT_W'(ts2_q[1] ^ ts3_q[1]);
			host_reads_o <= host_reads_o + CNT_W'(ts2_q[0] ^ ts3_q[0]);
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	logic [HALF_W:0] hi_len_q;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hi_len_q <= '0;
		end else begin
			hi_len_q <= sk_q ? hi_len_q + 1'b1 : '0;
		end
	end

	sk_fast_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$fell(sk_q) && spd_s2_q == SPEED_125MHZ && $stable(spd_s2_q) && !pd_s |-> hi_len_q == (HALF_W+1)'(HALF_FAST_CYC))
		else $error("serial clock high time wrong at fast speed");
	sk_slow_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		$fell(sk_q) && spd_s2_q == SPEED_25MHZ && $stable(spd_s2_q) && !pd_s |-> hi_len_q == (HALF_W+1)'(HALF_SLOW_CYC))
		else $error("serial clock high time wrong at slow speed");
	select_held_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == ST_CMD || state_q == ST_DATA |=> eeprom_select_o)
		else $error("select dropped during load");
	strap_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == ST_IDLE && !straps_q.eeprom_en |=> state_q == ST_DONE && !cs_q)
		else $error("loader ran without enable strap");
	strap_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q != ST_STRAP && $past(state_q) != ST_STRAP |-> $stable(straps_q))
		else $error("straps changed after capture");
	pd_tristate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		pd_s |=> !eeprom_select_oe_o && !eeprom_serial_out_oe_o && !eeprom_serial_clock_oe_o)
		else $error("pin driven during powerdown");
	out_change_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == ST_CMD && $changed(do_q) |-> !sk_q)
		else $error("serial out changed while clock high");
	data_sample_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
		state_q == ST_DATA && tick && sk_q |=> cfg_q[0] == $past(di_s))
		else $error("serial input bit not captured");
	qual_block_a: assert property (@(posedge host_clk_i) disable iff (!rst_n_i)
		hs2_q[2] |=> wr_tgl_q == $past(wr_tgl_q) && rd_tgl_q == $past(rd_tgl_q))
		else $error("access taken while qualifier high");

endmodule : scl_loader

// *** hdl/scl_pkg.sv ***
// constants and types of the strap and serial-memory configuration loader
package scl_pkg;

	// --------------------------------------------------------------
	// clock and serial clock timing
	// --------------------------------------------------------------
	localparam int CORE_CLK_MHZ = 200;
	localparam int SK_PERIOD_SLOW_NS = 4000;
	localparam int SK_PERIOD_FAST_NS = 800;
	localparam int HALF_SLOW_CYC = (SK_PERIOD_SLOW_NS * CORE_CLK_MHZ) / (2 * 1000);
	localparam int HALF_FAST_CYC = (SK_PERIOD_FAST_NS * CORE_CLK_MHZ) / (2 * 1000);
	localparam int HALF_W = 10;
	localparam logic [HALF_W-1:0] HALF_SLOW = HALF_W'(HALF_SLOW_CYC - 1);
	localparam logic [HALF_W-1:0] HALF_FAST = HALF_W'(HALF_FAST_CYC - 1);
	localparam logic [1:0] SPEED_25MHZ = 2'h3;
	localparam logic [1:0] SPEED_125MHZ = 2'h0;

	// --------------------------------------------------------------
	// strap capture and serial memory framing
	// --------------------------------------------------------------
	localparam logic [1:0] STRAP_WAIT = 2'h3;
	localparam int CMD_BITS = 9;
	localparam logic [CMD_BITS-1:0] READ_CMD = 9'h180;
	localparam int CFG_WORDS = 4;
	localparam int CFG_BITS = CFG_WORDS * 16;
	localparam int BIT_W = 7;
	localparam logic [BIT_W-1:0] CMD_LAST = BIT_W'(CMD_BITS - 1);
	localparam logic [BIT_W-1:0] CFG_LAST = BIT_W'(CFG_BITS - 1);
	localparam int CNT_W = 8;

	typedef enum logic [2:0] {
		ST_STRAP = 3'h0,
		ST_IDLE = 3'h1,
		ST_CMD = 3'h2,
		ST_DATA = 3'h3,
		ST_DONE = 3'h4
	} scl_state_t;

	typedef struct packed {
		logic eeprom_en;
		logic big_endian;
		logic bus_16bit;
	} scl_strap_t;

endpackage : scl_pkg

// *** verification/scl_eeprom_model.sv ***
// serial configuration memory model for the loader bench
`timescale 1ns/100ps
module scl_eeprom_model
	import scl_pkg::*;
#(
	parameter logic [CFG_BITS-1:0] MEM = 64'h0
)(
	input wire logic sk_i,
	input wire logic cs_i,
	input wire logic di_i,
	output logic do_o,
	output logic [CMD_BITS-1:0] cmd_o
);
	int n_rise = 0;
	initial do_o = 1'b0;
	initial cmd_o = '0;
	// --------------------------------------------------------------
	// serial access
	// --------------------------------------------------------------
	// deselect releases our output to the pin's pull-down level
	always @(posedge sk_i or negedge cs_i) begin
		if (!cs_i) begin
			n_rise <= 0;
			do_o <= 1'b0;
		end else begin
			n_rise <= n_rise + 1;
			if (n_rise < CMD_BITS)
				cmd_o <= {cmd_o[CMD_BITS-2:0], di_i};
			else if (n_rise < CMD_BITS + CFG_BITS)
				do_o <= MEM[CFG_BITS - 1 - (n_rise - CMD_BITS)];
		end
	end
endmodule : scl_eeprom_model

// *** verification/tb.sv ***
// self-checking bench of the configuration loader
`timescale 1ns/100ps
module tb;
	import scl_pkg::*;
	localparam logic [CFG_BITS-1:0] MEM = 64'hc3a5_0f1e_7d28_96b4;
	logic core_clk = 1'b0;
	logic host_clk = 1'b0;
	logic rst_n = 1'b0;
	logic en_strap = 1'b0;
	logic [1:0] speed = 2'h0;
	logic pd_n = 1'b1;
	logic sk_strap = 1'b0;
	logic in_strap = 1'b0;
	logic aq_n = 1'b1;
	logic wr_n = 1'b1;
	logic rd_n = 1'b1;
	logic sk_o, sk_oe, cs_o, cs_oe, do_o, do_oe, loaded, mem_do;
	logic [CFG_BITS-1:0] cfg;
	logic [CNT_W-1:0] nw, nr;
	logic [CMD_BITS-1:0] cmd;
	scl_strap_t straps;
	int n_mismatch = 0;
	int n_compared = 0;
	// pins resolve to the pad pull level when nobody drives them
	wire sk_pin = sk_oe ? sk_o : sk_strap;
	wire cs_pin = cs_oe ? cs_o : 1'b0;
	wire di_pin = do_oe ? do_o : 1'b0;
	wire in_pin = en_strap ? mem_do : in_strap;

	always #2.5 core_clk = ~core_clk;
	// odd start offset keeps the host clock out of phase with the core
	always begin
		#1.3;
		forever #7.5 host_clk = ~host_clk;
	end

	scl_loader dut_u (.core_clk_i(core_clk), .host_clk_i(host_clk), .rst_n_i(rst_n),
		.eeprom_enable_strap_i(en_strap), .onchip_bus_speed_control_i(speed),
		.chip_powerdown_n_i(pd_n), .eeprom_serial_clock_i(sk_pin), .eeprom_serial_clock_o(sk_o),
		.eeprom_serial_clock_oe_o(sk_oe), .eeprom_select_o(cs_o), .eeprom_select_oe_o(cs_oe),
		.eeprom_serial_out_o(do_o), .eeprom_serial_out_oe_o(do_oe), .eeprom_serial_in_i(in_pin),
		.address_qualifier_n_i(aq_n), .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n),
		.straps_o(straps), .config_loaded_o(loaded), .config_data_o(cfg),
		.host_writes_o(nw), .host_reads_o(nr));

	scl_eeprom_model #(.MEM(MEM)) mem_u (.sk_i(sk_pin), .cs_i(cs_pin), .di_i(di_pin),
		.do_o(mem_do), .cmd_o(cmd));

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	task automatic do_reset(logic en, logic [1:0] spd, logic sk, logic din, logic pd);
		cyc(1);
		rst_n = 1'b0;
		en_strap = en;
		speed = spd;
		sk_strap = sk;
		in_strap = din;
		pd_n = pd;
		cyc(12);
		rst_n = 1'b1;
		cyc(20);
	endtask : do_reset

	task automatic period(int exp_ns);
		time t1;
		@(posedge sk_pin);
		t1 = $time;
		@(posedge sk_pin);
		chk("sk period", exp_ns, $time - t1);
	endtask : period

	task automatic pulse(int n, bit wr);
		repeat (n) begin
			if (wr)
				wr_n = 1'b0;
			else
				rd_n = 1'b0;
			cyc(10);
			wr_n = 1'b1;
			rd_n = 1'b1;
			cyc(10);
		end
	endtask : pulse

	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_load();
		do_reset(1'b1, SPEED_125MHZ, 1'b0, 1'b0, 1'b0);
		chk("pd enables", 3'h0, {cs_oe, sk_oe, do_oe});
		pd_n = 1'b1;
		period(SK_PERIOD_FAST_NS);
		chk("select", 1'b1, cs_pin);
		for (int i = 0; i < 20000 && loaded !== 1'b1; i++)
			cyc(1);
		cyc(2);
		chk("loaded", 1'b1, loaded);
		chk("command", READ_CMD, cmd);
		chk("data", MEM, cfg);
		chk("select end", 1'b0, cs_pin);
		chk("straps", 3'h4, straps);
		$display("load test done");
	endtask : t_load

	task automatic t_slow();
		do_reset(1'b1, SPEED_25MHZ, 1'b1, 1'b0, 1'b1);
		period(SK_PERIOD_SLOW_NS);
		chk("straps", 3'h6, straps);
		$display("slow clock test done");
	endtask : t_slow

	task automatic t_nomem();
		for (int k = 0; k < 2; k++) begin
			do_reset(1'b0, SPEED_125MHZ, k[0], ~k[0], 1'b1);
			cyc(200);
			chk("straps", {1'b0, k[0], ~k[0]}, straps);
			chk("idle pins", 3'h0, {cs_pin, sk_oe, loaded});
		end
		$display("strap test done");
	endtask : t_nomem

	task automatic t_host();
		do_reset(1'b0, SPEED_125MHZ, 1'b0, 1'b0, 1'b1);
		aq_n = 1'b0;
		pulse(3, 1'b1);
		pulse(2, 1'b0);
		// strobes with qualifier high must leave no trace
		aq_n = 1'b1;
		pulse(2, 1'b1);
		pulse(2, 1'b0);
		cyc(20);
		chk("writes", 8'h03, nw);
		chk("reads", 8'h02, nr);
		$display("host strobe test done");
	endtask : t_host

	initial begin
		t_load();
		t_slow();
		t_nomem();
		t_host();
		complete_run();
	end

	// a hang counts against the run
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
endmodule : tb
